// [rtl/pmc_regs.vh]
// Register offsets, field positions, reset values and timing constants
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// ****************************************
// Register command codes
// ****************************************
`define PMC_ADDR_MODE 8'h12
`define PMC_ADDR_DISC 8'h13
`define PMC_ADDR_DETCL 8'h14
`define PMC_ADDR_TIMING 8'h16
`define PMC_ADDR_GMASK 8'h17
`define PMC_ADDR_RETRIG 8'h18

// ****************************************
// Field positions, codes, reset and read values
// ****************************************
`define PMC_MODE_OFF 2'h0
`define PMC_MODE_MANUAL 2'h1
`define PMC_MODE_SEMI 2'h2
`define PMC_MODE_AUTO 2'h3
`define PMC_DISCONNECT_DELAY_SEL_LSB 0
`define PMC_OVERCURRENT_FAULT_TIME_SEL_LSB 2
`define PMC_INRUSH_FAULT_TIME_SEL_LSB 4
`define PMC_GMASK_IRQ_BIT 7
`define PMC_GMASK_OSC_BIT 0
`define PMC_TIMING_RESET 8'h00
`define PMC_GMASK_RESET 8'h81
`define PMC_RETRIG_READ 8'h00

// ****************************************
// Timing in milliseconds, clock rate, hold percentage and decrement divider
// ****************************************
`define PMC_CLK_HZ 25000000
`define PMC_T30_MS 10'h01e
`define PMC_T60_MS 10'h03c
`define PMC_T90_MS 10'h05a
`define PMC_T120_MS 10'h078
`define PMC_T180_MS 10'h0b4
`define PMC_T240_MS 10'h0f0
`define PMC_T360_MS 10'h168
`define PMC_T720_MS 10'h2d0
`define PMC_TMPDO_MS 300
`define PMC_HOLD_PCT 17
`define PMC_DEC_DIV 16

`endif

// [rtl/pmc_port_mode_config.v]
// Per-port mode, disconnect and fault timing configuration bank
`timescale 1ns/10ps
`include "pmc_regs.vh"

// Operation
// - Two-bit mode per port: off/manual/semi/auto
// - Mode steers detect, classify and power-on automation
// - Mode, enables, AC disconnect reset to strap
// - AC high impedance runs timer, timeout disconnects
// - AC low impedance restarts timer from zero
// - DC low current runs timer, timeout disconnects
// - DC timer clears after current sustained for 17% of TMPDO
// - Manual enable runs one cycle, self-clears
// - Timing selections shared by all ports
// - Start window select: 60/30/120/240 ms
// - Overcurrent counter counts up, timeout powers off
// - Counter drains while off; turn-on refused
// - Below cut, decrement at 1/16 rate
// - Overcurrent timeout select: 60/30/120/240 ms
// - Disconnect delay: 360/90/180/720 ms when enabled
// - Global gate blocks interrupt output only
// - Oscillator mask blocks failure flag set
// - Restart write one triggers, zero ignored
// - Restart: manual single cycle, semi/auto enable bit
// - Restart register reads zero
// - Classification may run on all ports together
// - Port off command clears detect/classify enables
module pmc_port_mode_config #(
	parameter TICK_DIV = 25000,
	parameter TMPDO_MS = `PMC_TMPDO_MS
) (
	// Clock and reset
	input wire mclk_i,
	input wire rst_i,
	// Register access port
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	// Pins
	input wire auto_pin_i,
	// Per-port analog and state inputs
	input wire [3:0] ac_high_imp_i,
	input wire [3:0] dc_low_current_i,
	input wire [3:0] over_cut_i,
	input wire [3:0] foldback_i,
	input wire [3:0] port_on_i,
	input wire [3:0] port_off_cmd_i,
	input wire [3:0] turn_on_req_i,
	input wire [3:0] start_expired_i,
	input wire [3:0] detect_done_i,
	input wire [3:0] classify_done_i,
	input wire osc_fail_i,
	input wire [3:0] irq_pending_i,
	// Control outputs
	output reg [7:0] port_mode_o,
	output reg [3:0] detect_run_o,
	output reg [3:0] classify_run_o,
	output reg [3:0] detect_single_o,
	output reg [3:0] classify_single_o,
	output reg [3:0] power_auto_o,
	output reg [3:0] turn_on_grant_o,
	output reg [3:0] disconnect_off_o,
	output reg [3:0] port_disconnect_fault_flag_o,
	output reg [3:0] overcurrent_off_o,
	output reg [1:0] inrush_fault_time_sel_o,
	output reg oscillator_failure_flag_o,
	output reg irq_o
);

	localparam MS_CYC = `PMC_CLK_HZ / 1000;
	localparam HOLD_CYC = (TMPDO_MS * `PMC_HOLD_PCT * MS_CYC) / 100;

	// ****************************************
	// Timing decode, in millisecond ticks
	// ****************************************
	function [9:0] sel_ms;
		input [1:0] sel;
		input is_dis;
		begin
			case (sel)
			2'h0: sel_ms = is_dis ? `PMC_T360_MS : `PMC_T60_MS;
			2'h1: sel_ms = is_dis ? `PMC_T90_MS : `PMC_T30_MS;
			2'h2: sel_ms = is_dis ? `PMC_T180_MS : `PMC_T120_MS;
			default: sel_ms = is_dis ? `PMC_T720_MS : `PMC_T240_MS;
			endcase
		end
	endfunction

	// ****************************************
	// Strap synchroniser and register state
	// ****************************************
	reg auto_meta;
	reg auto_sync;
	reg strap_pending;
	reg [7:0] mode_reg;
	reg [7:0] disc_reg;
	reg [7:0] detcl_reg;
	reg [7:0] timing_reg;
	reg irq_gate;
	reg osc_gate;
	reg [14:0] tick_cnt;
	reg ms_tick;
	reg [3:0] dec_div;
	reg [9:0] dis_cnt [0:3];
	reg [9:0] oc_cnt [0:3];
	reg [23:0] hold_cnt [0:3];
	integer i;
	integer c;
	integer k;

	wire [1:0] disconnect_delay_sel_sel = timing_reg[`PMC_DISCONNECT_DELAY_SEL_LSB+1:`PMC_DISCONNECT_DELAY_SEL_LSB];
	wire [1:0] overcurrent_fault_time_sel_sel = timing_reg[`PMC_OVERCURRENT_FAULT_TIME_SEL_LSB+1:`PMC_OVERCURRENT_FAULT_TIME_SEL_LSB];
	wire [9:0] dis_lim = sel_ms(disconnect_delay_sel_sel, 1'b1);
	wire [9:0] oc_lim = sel_ms(overcurrent_fault_time_sel_sel, 1'b0);
	wire wr_mode = reg_wr_i && reg_addr_i == `PMC_ADDR_MODE;
	wire wr_detcl = reg_wr_i && reg_addr_i == `PMC_ADDR_DETCL;
	wire wr_retrig = reg_wr_i && reg_addr_i == `PMC_ADDR_RETRIG;

	// ****************************************
	// Next value of the enable register
	// ****************************************
	reg [7:0] next_detcl;
	reg [3:0] next_det_single;
	reg [3:0] next_cl_single;
	reg [3:0] lost;
	reg [1:0] m;
	always @* begin
		next_detcl = detcl_reg;
		next_det_single = 4'h0;
		next_cl_single = 4'h0;
		lost = disconnect_off_o | overcurrent_off_o | port_off_cmd_i;
		if (wr_detcl)
			next_detcl = reg_wdata_i;
		for (c = 0; c < 4; c = c + 1) begin
			m = mode_reg[2*c +: 2];
			if (m == `PMC_MODE_MANUAL) begin
				if (detect_done_i[c])
					next_detcl[c] = 1'b0;
				if (classify_done_i[c])
					next_detcl[c+4] = 1'b0;
			end
			if (wr_retrig && reg_wdata_i[c]) begin
				if (m == `PMC_MODE_MANUAL)
					next_det_single[c] = 1'b1;
				else if (m != `PMC_MODE_OFF)
					next_detcl[c] = 1'b1;
			end
			if (wr_retrig && reg_wdata_i[c+4]) begin
				if (m == `PMC_MODE_MANUAL)
					next_cl_single[c] = 1'b1;
				else if (m != `PMC_MODE_OFF)
					next_detcl[c+4] = 1'b1;
			end
			if (lost[c]) begin
				next_detcl[c] = 1'b0;
				next_detcl[c+4] = 1'b0;
			end
		end
	end

	// ****************************************
	// Register writes, strap capture, tick
	// ****************************************
	always @(posedge mclk_i) begin
		if (rst_i) begin
			auto_meta <= 1'b0;
			auto_sync <= 1'b0;
			strap_pending <= 1'b1;
			mode_reg <= 8'h00;
			disc_reg <= 8'h00;
			detcl_reg <= 8'h00;
			timing_reg <= `PMC_TIMING_RESET;
			irq_gate <= 1'b1;
			osc_gate <= 1'b1;
			tick_cnt <= 15'h0000;
			ms_tick <= 1'b0;
			dec_div <= 4'h0;
		end else begin
			auto_meta <= auto_pin_i;
			auto_sync <= auto_meta;
			tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 15'h0000 :
				tick_cnt + 15'h0001;
			ms_tick <= (tick_cnt == TICK_DIV - 1);
			if (ms_tick)
				dec_div <= dec_div + 4'h1;
			// Strap lands once synchroniser has settled
			if (strap_pending && tick_cnt == 15'h0002) begin
				strap_pending <= 1'b0;
				mode_reg <= {8{auto_sync}};
				disc_reg <= {{4{auto_sync}}, 4'h0};
				detcl_reg <= {8{auto_sync}};
			end else begin
				if (wr_mode)
					mode_reg <= reg_wdata_i;
				if (reg_wr_i && reg_addr_i == `PMC_ADDR_DISC)
					disc_reg <= reg_wdata_i;
				detcl_reg <= next_detcl;
			end
			if (reg_wr_i && reg_addr_i == `PMC_ADDR_TIMING)
				timing_reg <= {2'h0, reg_wdata_i[5:0]};
			if (reg_wr_i && reg_addr_i == `PMC_ADDR_GMASK) begin
				irq_gate <= reg_wdata_i[`PMC_GMASK_IRQ_BIT];
				osc_gate <= reg_wdata_i[`PMC_GMASK_OSC_BIT];
			end
		end
	end

	// ****************************************
	// Per-port disconnect and overcurrent timers
	// ****************************************
	always @(posedge mclk_i) begin
		if (rst_i) begin
			for (i = 0; i < 4; i = i + 1) begin
				dis_cnt[i] <= 10'h000;
				oc_cnt[i] <= 10'h000;
				hold_cnt[i] <= 24'h000000;
			end
			disconnect_off_o <= 4'h0;
			overcurrent_off_o <= 4'h0;
			port_disconnect_fault_flag_o <= 4'h0;
			turn_on_grant_o <= 4'h0;
		end else begin
			for (i = 0; i < 4; i = i + 1) begin
				disconnect_off_o[i] <= 1'b0;
				overcurrent_off_o[i] <= 1'b0;
				// Fault flag cleared by off command; new fault wins
				if (port_off_cmd_i[i])
					port_disconnect_fault_flag_o[i] <= 1'b0;
				// Disconnect delay only with a method enabled
				if (!port_on_i[i] || !(disc_reg[i] | disc_reg[i+4])) begin
					dis_cnt[i] <= 10'h000;
					hold_cnt[i] <= 24'h000000;
				end else if (disc_reg[i+4] && ac_high_imp_i[i] == 1'b0) begin
					dis_cnt[i] <= 10'h000;
				end else if (disc_reg[i] && !dc_low_current_i[i]) begin
					// DC: needs uninterrupted current before clearing
					if (hold_cnt[i] >= HOLD_CYC - 1) begin
						dis_cnt[i] <= 10'h000;
						hold_cnt[i] <= 24'h000000;
					end else begin
						hold_cnt[i] <= hold_cnt[i] + 24'h000001;
					end
				end else begin
					hold_cnt[i] <= 24'h000000;
					if (ms_tick) begin
						if (dis_cnt[i] + 10'h001 >= dis_lim) begin
							dis_cnt[i] <= 10'h000;
							disconnect_off_o[i] <= 1'b1;
							port_disconnect_fault_flag_o[i] <= 1'b1;
						end else begin
							dis_cnt[i] <= dis_cnt[i] + 10'h001;
						end
					end
				end
				// Overcurrent counter, shared timeout select
				if (port_on_i[i] && start_expired_i[i] && over_cut_i[i]) begin
					if (ms_tick) begin
						if (oc_cnt[i] + 10'h001 >= oc_lim) begin
							oc_cnt[i] <= oc_lim;
							overcurrent_off_o[i] <= 1'b1;
						end else begin
							oc_cnt[i] <= oc_cnt[i] + 10'h001;
						end
					end
				end else if (ms_tick && dec_div == 4'hf &&
					!foldback_i[i] && oc_cnt[i] != 10'h000) begin
					oc_cnt[i] <= oc_cnt[i] - 10'h001;
				end
				turn_on_grant_o[i] <= turn_on_req_i[i] &&
					oc_cnt[i] == 10'h000 && !port_off_cmd_i[i];
			end
		end
	end

	// ****************************************
	// Mode decode, flags, interrupt, read data
	// ****************************************
	always @(posedge mclk_i) begin
		if (rst_i) begin
			port_mode_o <= 8'h00;
			detect_run_o <= 4'h0;
			classify_run_o <= 4'h0;
			detect_single_o <= 4'h0;
			classify_single_o <= 4'h0;
			power_auto_o <= 4'h0;
			inrush_fault_time_sel_o <= 2'h0;
			oscillator_failure_flag_o <= 1'b0;
			irq_o <= 1'b0;
			reg_rdata_o <= 8'h00;
		end else begin
			port_mode_o <= mode_reg;
			for (k = 0; k < 4; k = k + 1) begin
				// Off ports get no detection or class at all
				detect_run_o[k] <= mode_reg[2*k +: 2] != `PMC_MODE_OFF &&
					detcl_reg[k];
				// No port interlock: classes may overlap
				classify_run_o[k] <= mode_reg[2*k +: 2] != `PMC_MODE_OFF &&
					detcl_reg[k+4];
				power_auto_o[k] <=
					mode_reg[2*k +: 2] == `PMC_MODE_AUTO;
			end
			detect_single_o <= next_det_single;
			classify_single_o <= next_cl_single;
			inrush_fault_time_sel_o <=
				timing_reg[`PMC_INRUSH_FAULT_TIME_SEL_LSB+1:`PMC_INRUSH_FAULT_TIME_SEL_LSB];
			if (osc_fail_i && osc_gate)
				oscillator_failure_flag_o <= 1'b1;
			irq_o <= irq_gate && (|irq_pending_i);
			case (reg_addr_i)
			`PMC_ADDR_MODE: reg_rdata_o <= mode_reg;
			`PMC_ADDR_DISC: reg_rdata_o <= disc_reg;
			`PMC_ADDR_DETCL: reg_rdata_o <= detcl_reg;
			`PMC_ADDR_TIMING: reg_rdata_o <= timing_reg;
			`PMC_ADDR_GMASK:
				reg_rdata_o <= {irq_gate, 6'h00, osc_gate};
			`PMC_ADDR_RETRIG: reg_rdata_o <= `PMC_RETRIG_READ;
			default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

endmodule

// [bench/pmc_host.sv]
// Host processor model driving the register access port
`timescale 1ns/10ps
module pmc_host (
	// Clock
	input wire mclk_i,
	// Register access port
	input wire [7:0] rdata_i,
	output reg wr_o = 1'b0,
	output reg rd_o = 1'b0,
	output reg [7:0] addr_o = 8'h00,
	output reg [7:0] wdata_o = 8'h00
);
	// Strobe stands for exactly one edge
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge mclk_i);
			wr_o = 1'b1;
			addr_o = a;
			wdata_o = d;
			@(negedge mclk_i);
			wr_o = 1'b0;
			// Released data must not look valid
			wdata_o = ~d;
		end
	endtask
	// Data is registered, so wait two edges
	task rd(input [7:0] a, output [7:0] v);
		begin
			@(negedge mclk_i);
			rd_o = 1'b1;
			addr_o = a;
			repeat (2) @(negedge mclk_i);
			v = rdata_i;
			rd_o = 1'b0;
		end
	endtask
endmodule

// [bench/pmc_port_mode_config_properties.sv]
// Port checker for the mode configuration bank
`timescale 1ns/10ps
module pmc_props (
	input logic mclk_i, rst_i, reg_wr_i, irq_o, oscillator_failure_flag_o,
	input logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, port_mode_o,
	input logic [3:0] power_auto_o, detect_run_o, detect_single_o,
	input logic [3:0] irq_pending_i, turn_on_req_i, turn_on_grant_o
);
	logic [7:0] last_mode;
	logic osc_en;
	logic [2:0] age;
	logic mw;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Strap overwrites early writes, so skip them
	assign mw = reg_wr_i && reg_addr_i == 8'h12 && age == 3'h7;
	always @(posedge mclk_i) begin
		if (rst_i) begin
			age <= 3'h0;
			osc_en <= 1'b1;
		end else begin
			if (age != 3'h7)
				age <= age + 3'h1;
			if (reg_wr_i && reg_addr_i == 8'h17)
				osc_en <= reg_wdata_i[0];
		end
		if (reg_wr_i && reg_addr_i == 8'h12)
			last_mode <= reg_wdata_i;
	end
	mode_write_a: assert property (mw |-> ##[1:3] port_mode_o == last_mode)
		else $error("mode write lost");
	auto_power_a: assert property (power_auto_o[3] == &port_mode_o[7:6])
		else $error("auto power mismatch");
	run_not_off_a: assert property (detect_run_o[0] |-> port_mode_o[1:0] != 2'h0)
		else $error("detection in off mode");
	single_manual_a: assert property (detect_single_o[1] |-> port_mode_o[3:2] == 2'h1)
		else $error("single cycle outside manual");
	retrig_read_a: assert property (reg_addr_i == 8'h18 |=> reg_rdata_o == 8'h00)
		else $error("restart read nonzero");
	irq_cause_a: assert property (irq_o |-> $past(irq_pending_i) != 4'h0)
		else $error("irq without source");
	irq_gate_a: assert property (reg_wr_i && reg_addr_i == 8'h17 && !reg_wdata_i[7] |-> ##3 !irq_o)
		else $error("irq not gated");
	osc_gate_a: assert property ($rose(oscillator_failure_flag_o) |-> $past(osc_en) || $past(osc_en, 2))
		else $error("osc flag while masked");
	grant_req_a: assert property ((turn_on_grant_o & ~$past(turn_on_req_i)) == 4'h0)
		else $error("grant without request");
endmodule
bind pmc_port_mode_config pmc_props chk_u (.mclk_i, .rst_i, .reg_wr_i,
	.irq_o, .oscillator_failure_flag_o, .reg_addr_i, .reg_wdata_i,
	.reg_rdata_o, .port_mode_o, .power_auto_o, .detect_run_o,
	.detect_single_o, .irq_pending_i, .turn_on_req_i, .turn_on_grant_o);

// [bench/tb_pmc_port_mode_config.sv]
// Self-checking bench for the mode configuration bank
`timescale 1ns/10ps
module tb_pmc_port_mode_config;
	reg mclk_i = 0, rst_i = 1, auto_pin_i = 1, osc_fail_i = 0;
	reg [3:0] ac_high_imp_i = 0, dc_low_current_i = 0, over_cut_i = 0;
	reg [3:0] foldback_i = 0, port_on_i = 4'hf, port_off_cmd_i = 0;
	reg [3:0] turn_on_req_i = 0, start_expired_i = 4'hf, irq_pending_i = 0;
	reg [3:0] detect_done_i = 0, classify_done_i = 0, sing = 0;
	wire reg_wr_i, reg_rd_i, oscillator_failure_flag_o, irq_o;
	wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, port_mode_o;
	wire [3:0] detect_run_o, classify_run_o, detect_single_o, power_auto_o;
	wire [3:0] classify_single_o, turn_on_grant_o, disconnect_off_o;
	wire [3:0] port_disconnect_fault_flag_o, overcurrent_off_o;
	wire [1:0] inrush_fault_time_sel_o;
	integer failures = 0, num_checks = 0, n;
	reg [7:0] v;
	// Short ms tick keeps the timers in reach
	pmc_port_mode_config #(.TICK_DIV(4), .TMPDO_MS(1)) dut_u (.mclk_i,
		.rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .auto_pin_i, .ac_high_imp_i, .dc_low_current_i,
		.over_cut_i, .foldback_i, .port_on_i, .port_off_cmd_i,
		.turn_on_req_i, .start_expired_i, .detect_done_i, .classify_done_i,
		.osc_fail_i, .irq_pending_i, .port_mode_o, .detect_run_o,
		.classify_run_o, .detect_single_o, .classify_single_o, .power_auto_o,
		.turn_on_grant_o, .disconnect_off_o, .port_disconnect_fault_flag_o,
		.overcurrent_off_o, .inrush_fault_time_sel_o,
		.oscillator_failure_flag_o, .irq_o);
	pmc_host host_u (.mclk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
		.rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
	initial forever #20 mclk_i = ~mclk_i;
	always @(posedge mclk_i) sing <= sing | detect_single_o;
	task chk(input [7:0] s, input [7:0] e);
		begin
			num_checks = num_checks + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		begin
			host_u.rd(a, v);
			chk(v, e);
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge mclk_i);
	endtask
	task report_and_stop;
		begin
			$display("checks=%0d failures=%0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// A spent wait bound ends the run
	task bound(input integer m);
		if (n >= m) begin
			failures = failures + 1;
			report_and_stop;
		end
	endtask
	initial begin
		cyc(5);
		rst_i = 0;
		cyc(6);
		rc(8'h12, 8'hff);
		rc(8'h13, 8'hf0);
		rc(8'h14, 8'hff);
		rc(8'h16, 8'h00);
		rc(8'h17, 8'h81);
		rc(8'h18, 8'h00);
		host_u.wr(8'h16, 8'hff);
		rc(8'h16, 8'h3f);
		host_u.wr(8'h17, 8'hff);
		rc(8'h17, 8'h81);
		rc(8'h15, 8'h00);
		$display("reset and reserved done");
		host_u.wr(8'h12, 8'he4);
		rc(8'h12, 8'he4);
		chk(power_auto_o, 8'h08);
		chk(detect_run_o, 8'h0e);
		host_u.wr(8'h14, 8'h00);
		host_u.wr(8'h18, 8'h00);
		rc(8'h14, 8'h00);
		host_u.wr(8'h18, 8'hff);
		rc(8'h14, 8'hcc);
		chk(sing, 8'h02);
		port_off_cmd_i = 4'h8;
		cyc(1);
		port_off_cmd_i = 0;
		rc(8'h14, 8'h44);
		host_u.wr(8'h14, 8'h02);
		detect_done_i = 4'h2;
		cyc(1);
		detect_done_i = 0;
		rc(8'h14, 8'h00);
		$display("modes and restart done");
		irq_pending_i = 4'h1;
		cyc(3);
		chk(irq_o, 8'h01);
		host_u.wr(8'h17, 8'h01);
		cyc(3);
		chk(irq_o, 8'h00);
		host_u.wr(8'h17, 8'h00);
		osc_fail_i = 1;
		cyc(4);
		chk(oscillator_failure_flag_o, 8'h00);
		host_u.wr(8'h17, 8'h01);
		cyc(4);
		chk(oscillator_failure_flag_o, 8'h01);
		$display("masks done");
		// 30 ms cut timeout, 90 ms disconnect, 240 ms start window
		host_u.wr(8'h12, 8'he7);
		host_u.wr(8'h16, 8'h35);
		cyc(2);
		chk(inrush_fault_time_sel_o, 8'h03);
		over_cut_i = 4'h1;
		for (n = 0; n < 600 && !overcurrent_off_o[0]; n = n + 1) cyc(1);
		bound(600);
		over_cut_i = 0;
		turn_on_req_i = 4'h1;
		chk(n >= 112 && n <= 128, 8'h01);
		cyc(2);
		chk(turn_on_grant_o, 8'h00);
		for (n = 0; n < 2500 && !turn_on_grant_o[0]; n = n + 1) cyc(1);
		bound(2500);
		chk(n >= 1850 && n <= 1990, 8'h01);
		$display("overcurrent done");
		host_u.wr(8'h13, 8'h10);
		ac_high_imp_i = 4'h1;
		cyc(200);
		ac_high_imp_i = 0;
		cyc(2);
		ac_high_imp_i = 4'h1;
		for (n = 0; n < 600 && !disconnect_off_o[0]; n = n + 1) cyc(1);
		bound(600);
		chk(n >= 352 && n <= 370, 8'h01);
		cyc(1);
		chk(port_disconnect_fault_flag_o, 8'h01);
		// AC low impedance clears the timer until DC takes over
		ac_high_imp_i = 0;
		dc_low_current_i = 4'h1;
		host_u.wr(8'h13, 8'h01);
		for (n = 0; n < 600 && !disconnect_off_o[0]; n = n + 1) cyc(1);
		bound(600);
		chk(n >= 352 && n <= 370, 8'h01);
		dc_low_current_i = 0;
		$display("disconnect done");
		report_and_stop;
	end
endmodule
